// ==== verilog/mps_pkg.sv ====
// constants for the memory module power sequencer
// assumes a single 125 MHz clock; all analog sensing arrives as pins
package mps_pkg;
    localparam int CLK_FREQ_HZ = 125000000;
    // turn-on delay pulse length, least time, rounded up
    localparam int TURN_ON_DELAY_MS = 30;
    localparam int TURN_ON_DELAY_CYC = (CLK_FREQ_HZ / 1000) * TURN_ON_DELAY_MS;
    // settle time before fault indication is allowed
    localparam int SETTLE_DELAY_MS = 150;
    localparam int SETTLE_DELAY_CYC = (CLK_FREQ_HZ / 1000) * SETTLE_DELAY_MS;
    localparam int CNT_W = 25;
    // index of each module regulator in per-regulator vectors
    localparam int REG_READ = 0;
    localparam int REG_WRITE = 1;
    localparam int REG_INHIBIT = 2;
    localparam int REG_POS30 = 3;
    localparam int NUM_REG = 4;
    // relay chain states
    typedef enum logic [3:0] {
        MPS_RLY_OFF = 4'h1,
        MPS_RLY_ST1 = 4'h2,
        MPS_RLY_ST2 = 4'h4,
        MPS_RLY_ST3 = 4'h8
    } mps_relay_e;
endpackage

// ==== verilog/mps_delay.sv ====
// one-shot delay counter: pulse of fixed length or delayed level
// assumes run comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module mps_delay #(
    parameter int CYCLES = 4
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    output logic done_out
);
    logic [mps_pkg::CNT_W-1:0] count;

    // counts while run is high, holds done once reached, clears count and done when run drops
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= '0;
            done_out <= 1'b0;
        end else if (!run_in) begin
            count <= '0;
            done_out <= 1'b0;
        end else if (count == mps_pkg::CNT_W'(CYCLES - 1)) begin
            done_out <= 1'b1;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/mps_top.sv ====
// power sequencer and supply fault logic of one core memory module
// assumes every input is an asynchronous pin from relays, switches or comparators
`timescale 1ns/1ps
`default_nettype none
// delay lengths default to the real timings; a bench may shorten them to reach later states
module mps_top #(
    parameter int TURN_ON_CYC = mps_pkg::TURN_ON_DELAY_CYC,
    parameter int SETTLE_CYC = mps_pkg::SETTLE_DELAY_CYC
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic power_switch_on_in,
    input wire logic remote_mode_in,
    input wire logic system_on_in,
    input wire logic hv_supply_good_in,
    input wire logic [3:0] reg_undervoltage_in,
    input wire logic [3:0] reg_overvoltage_in,
    input wire logic fault_reset_in,
    output logic first_stage_relay_out,
    output logic second_stage_relay_out,
    output logic third_stage_relay_out,
    output logic fault_indicate_relay_out,
    output logic neg30_enable_n_out,
    output logic pos30_enable_out,
    output logic power_up_latch_out,
    output logic turn_on_delay_pulse_out,
    output logic supply_fault_block_n_out,
    output logic memory_not_available_out,
    output logic undervoltage_indicator_n_out,
    output logic overvoltage_indicator_n_out,
    output logic [3:0] reg_fault_indicator_n_out
);
    // ------------------------------------------------------------
    // reset and pin synchronisers
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    localparam int NSYNC = 13;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] pins_meta;
    logic [NSYNC-1:0] pins;
    assign pins_raw = {reg_overvoltage_in, reg_undervoltage_in, fault_reset_in,
        hv_supply_good_in, system_on_in, remote_mode_in, power_switch_on_in};

    // two flops per pin before any logic looks at it
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta <= '0;
            pins <= '0;
        end else begin
            pins_meta <= pins_raw;
            pins <= pins_meta;
        end
    end

    logic sw_on;
    logic remote;
    logic sys_on;
    logic hv_good;
    logic fault_reset;
    logic [3:0] uv;
    logic [3:0] ov;
    assign sw_on = pins[0];
    assign remote = pins[1];
    assign sys_on = pins[2];
    assign hv_good = pins[3];
    assign fault_reset = pins[4];
    assign uv = pins[8:5];
    assign ov = pins[12:9];

    // ------------------------------------------------------------
    // relay chain
    // ------------------------------------------------------------
    mps_pkg::mps_relay_e relay_state;
    mps_pkg::mps_relay_e next_relay_state;

    // pick upward one stage per cycle, drop downward one per cycle
    always_comb begin
        next_relay_state = relay_state;
        case (relay_state)
            mps_pkg::MPS_RLY_OFF: begin
                if (sw_on && sys_on) next_relay_state = mps_pkg::MPS_RLY_ST1;
            end
            mps_pkg::MPS_RLY_ST1: begin
                if (!sw_on || !sys_on) next_relay_state = mps_pkg::MPS_RLY_OFF;
                else next_relay_state = mps_pkg::MPS_RLY_ST2;
            end
            mps_pkg::MPS_RLY_ST2: begin
                if (!sw_on || !sys_on) next_relay_state = mps_pkg::MPS_RLY_ST1;
                else next_relay_state = mps_pkg::MPS_RLY_ST3;
            end
            mps_pkg::MPS_RLY_ST3: begin
                if (!sw_on || !sys_on) next_relay_state = mps_pkg::MPS_RLY_ST2;
            end
            default: next_relay_state = mps_pkg::MPS_RLY_OFF;
        endcase
    end

    // the chain runs only with system power present, independent of remote
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            relay_state <= mps_pkg::MPS_RLY_OFF;
        end else begin
            relay_state <= next_relay_state;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            first_stage_relay_out <= 1'b0;
            second_stage_relay_out <= 1'b0;
            third_stage_relay_out <= 1'b0;
        end else begin
            first_stage_relay_out <= (next_relay_state != mps_pkg::MPS_RLY_OFF);
            second_stage_relay_out <= (next_relay_state == mps_pkg::MPS_RLY_ST2)
                || (next_relay_state == mps_pkg::MPS_RLY_ST3);
            third_stage_relay_out <= (next_relay_state == mps_pkg::MPS_RLY_ST3);
        end
    end

    // ------------------------------------------------------------
    // fault indication settle delay
    // ------------------------------------------------------------
    logic settle_done;
    mps_delay #(
        .CYCLES(SETTLE_CYC)
    ) u_settle (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .run_in(second_stage_relay_out),
        .done_out(settle_done)
    );

    // indicate relay follows +19V from the second stage after 150 ms
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            fault_indicate_relay_out <= 1'b0;
        end else begin
            fault_indicate_relay_out <= settle_done && second_stage_relay_out;
        end
    end

    // ------------------------------------------------------------
    // turn-on delay pulse and power-up latch
    // ------------------------------------------------------------
    logic hv_good_prev;
    logic pulse_run;
    logic pulse_done;
    logic pulse_start;
    logic sequence_ok;

    // +100V is only taken as good once the third relay carries it
    assign sequence_ok = hv_good && third_stage_relay_out;
    assign pulse_start = sequence_ok && !hv_good_prev && !power_up_latch_out
        && supply_fault_block_n_out;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            hv_good_prev <= 1'b0;
        end else begin
            hv_good_prev <= sequence_ok;
        end
    end

    mps_delay #(
        .CYCLES(TURN_ON_CYC)
    ) u_turn_on (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .run_in(pulse_run),
        .done_out(pulse_done)
    );

    // pulse is dropped early if +100V goes away mid-pulse
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pulse_run <= 1'b0;
        end else if (pulse_start) begin
            pulse_run <= 1'b1;
        end else if (pulse_done || !sequence_ok) begin
            pulse_run <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            turn_on_delay_pulse_out <= 1'b0;
        end else begin
            turn_on_delay_pulse_out <= pulse_run && !pulse_done;
        end
    end

    // latch clears first on +100V loss or lockout loss
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            power_up_latch_out <= 1'b0;
        end else if (!sequence_ok || !supply_fault_block_n_out) begin
            power_up_latch_out <= 1'b0;
        end else if (turn_on_delay_pulse_out) begin
            power_up_latch_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // regulator enables
    // ------------------------------------------------------------
    logic neg30_uv_any;
    assign neg30_uv_any = |uv[2:0];

    // -30V group on from pulse start, held by latch, dropped once +30V is down
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            neg30_enable_n_out <= 1'b1;
        end else if (turn_on_delay_pulse_out || power_up_latch_out) begin
            neg30_enable_n_out <= 1'b0;
        end else if (!pos30_enable_out) begin
            neg30_enable_n_out <= 1'b1;
        end
    end

    // +30V follows -30V, and goes down before it on shutdown
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pos30_enable_out <= 1'b0;
        end else if (!power_up_latch_out || (uv[mps_pkg::REG_POS30]
            && !turn_on_delay_pulse_out && pos30_enable_out)) begin
            pos30_enable_out <= 1'b0;
        end else if (!neg30_enable_n_out && !neg30_uv_any) begin
            pos30_enable_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // fault latches
    // ------------------------------------------------------------
    logic sense_arm;
    logic latch_clear;
    logic uv_latch;
    logic ov_latch;
    logic [3:0] reg_latch;

    // sensing armed only after the pulse, with settle relay closed
    assign sense_arm = power_up_latch_out && !turn_on_delay_pulse_out
        && fault_indicate_relay_out && !fault_reset;
    assign latch_clear = fault_reset || !sw_on;

    // set wins over clear: reset button also disables sensing, so only a switch-off clear can clash with a set
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            uv_latch <= 1'b0;
        end else if (sense_arm && (|uv)) begin
            uv_latch <= 1'b1;
        end else if (latch_clear) begin
            uv_latch <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            ov_latch <= 1'b0;
        end else if (sense_arm && (|ov)) begin
            ov_latch <= 1'b1;
        end else if (latch_clear) begin
            ov_latch <= 1'b0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < mps_pkg::NUM_REG; gi++) begin : g_reg
            logic gate_ok;
            // +30V indication suppressed while a -30V rail is under-voltage
            if (gi == mps_pkg::REG_POS30) begin : g_pos
                assign gate_ok = !neg30_uv_any;
            end else begin : g_neg
                assign gate_ok = 1'b1;
            end
            always_ff @(posedge clock_in or negedge rst_n) begin
                if (!rst_n) begin
                    reg_latch[gi] <= 1'b0;
                end else if (sense_arm && gate_ok && (uv[gi] || ov[gi])) begin
                    reg_latch[gi] <= 1'b1;
                end else if (latch_clear) begin
                    reg_latch[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            undervoltage_indicator_n_out <= 1'b1;
            overvoltage_indicator_n_out <= 1'b1;
            reg_fault_indicator_n_out <= 4'hf;
        end else begin
            undervoltage_indicator_n_out <= !uv_latch;
            overvoltage_indicator_n_out <= !ov_latch;
            reg_fault_indicator_n_out <= ~reg_latch;
        end
    end

    // ------------------------------------------------------------
    // lockout and availability
    // ------------------------------------------------------------
    // lockout is the only path to system power off, and only on a fault in remote mode
    // lockout is held true in local mode, so off-line faults stay local
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            supply_fault_block_n_out <= 1'b1;
        end else begin
            supply_fault_block_n_out <= !(remote && (|reg_latch)
                && (uv_latch || ov_latch));
        end
    end

    // exchange takes a low level here as module ready
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            memory_not_available_out <= 1'b1;
        end else begin
            memory_not_available_out <= !(pos30_enable_out && !uv[mps_pkg::REG_POS30]
                && !turn_on_delay_pulse_out && power_up_latch_out);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    relay_order_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        third_stage_relay_out |-> second_stage_relay_out && first_stage_relay_out)
        else $error("third relay closed without earlier stages");

    relay_drop_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        $fell(first_stage_relay_out) |-> !$past(second_stage_relay_out))
        else $error("first relay dropped before second");

    pos30_after_neg_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        $rose(pos30_enable_out) |-> !neg30_enable_n_out && !$past(neg30_uv_any))
        else $error("+30V enabled before -30V group up");

    neg_after_pos_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        $rose(neg30_enable_n_out) |-> !$past(pos30_enable_out))
        else $error("-30V dropped while +30V still on");

    latch_clear_hv_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        !sequence_ok |=> !power_up_latch_out)
        else $error("power-up latch held without +100V");

    pulse_start_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        pulse_start |-> ##2 turn_on_delay_pulse_out || !sequence_ok)
        else $error("delay pulse did not start");

    mna_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        turn_on_delay_pulse_out |=> memory_not_available_out)
        else $error("memory reported available during delay pulse");

    lockout_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        !supply_fault_block_n_out |-> (|$past(reg_latch))
        && ($past(uv_latch) || $past(ov_latch)))
        else $error("lockout dropped without both latches");

    uv_sense_a: assert property (@(posedge clock_in) disable iff (!rst_n)
        sense_arm && uv[0] |=> ##1 !undervoltage_indicator_n_out)
        else $error("under-voltage not latched");
endmodule
`default_nettype wire

// ==== verification/mps_supply_model.sv ====
// system power controller and memory exchange model facing the sequencer
// assumes the bench commands system power, +100V and forced sense faults; regulator outputs ramp
// a fixed number of cycles after their enables
`timescale 1ns/1ps
`default_nettype none
module mps_supply_model #(
    parameter int RAMP_CYC = 4
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic sys_power_in,
    input wire logic hv_request_in,
    input wire logic neg30_enable_n_in,
    input wire logic pos30_enable_in,
    input wire logic supply_fault_block_n_in,
    input wire logic memory_not_available_in,
    input wire logic [3:0] trip_uv_in,
    input wire logic [3:0] trip_ov_in,
    output logic system_on_out,
    output logic hv_supply_good_out,
    output logic [3:0] reg_undervoltage_out,
    output logic [3:0] reg_overvoltage_out,
    output logic module_ready_out
);
    int neg_up;
    int pos_up;

    // ----------------------------------------
    // supplies and regulator sensing
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            system_on_out <= 1'b0;
            hv_supply_good_out <= 1'b0;
            reg_undervoltage_out <= 4'hf;
            reg_overvoltage_out <= 4'h0;
            module_ready_out <= 1'b0;
            neg_up <= 0;
            pos_up <= 0;
        end else begin
            system_on_out <= sys_power_in;
            // +100V is only switched on while lockout is true
            hv_supply_good_out <= hv_request_in && supply_fault_block_n_in;
            neg_up <= neg30_enable_n_in ? 0 : ((neg_up < RAMP_CYC) ? neg_up + 1 : neg_up);
            pos_up <= !pos30_enable_in ? 0 : ((pos_up < RAMP_CYC) ? pos_up + 1 : pos_up);
            // a disabled regulator reads under-voltage at once, so down order shows
            // a forced trip stands for an excess-current shutdown of that regulator
            reg_undervoltage_out[2:0] <= trip_uv_in[2:0]
                | ((neg30_enable_n_in || neg_up < RAMP_CYC) ? 3'h7 : 3'h0);
            reg_undervoltage_out[3] <= trip_uv_in[3] || !pos30_enable_in
                || pos_up < RAMP_CYC;
            reg_overvoltage_out <= trip_ov_in;
            module_ready_out <= !memory_not_available_in;
        end
    end
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the memory module power sequencer
// assumes the supply model on the far side; long delays are not waited out
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic switch_on = 1'b0;
    logic sys_power = 1'b1;
    logic hv_request = 1'b0;
    logic remote = 1'b1;
    logic fault_reset = 1'b0;
    logic ready;
    logic [3:0] trip_uv = 4'h0;
    logic [3:0] trip_ov = 4'h0;
    // short delays so the run can reach the states behind them
    localparam int PULSE_CYC = 60;
    localparam int SETTLE_CYC = 30;
    logic system_on, hv_good, k1, k2, k3, k4, neg30_n, pos30, latch, pulse, lockout_n, mna;
    logic uv_ind_n, ov_ind_n;
    logic [3:0] uv, ov, reg_ind_n;
    logic [6:0] mon;
    int t [7];
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;

    assign mon = {pulse, latch, pos30, neg30_n, k3, k2, k1};

    initial begin
        forever #4 clock = ~clock;
    end

    mps_top #(.TURN_ON_CYC(PULSE_CYC), .SETTLE_CYC(SETTLE_CYC)) mps_top_i (.clock_in(clock),
        .rst_n_in(rst_n), .power_switch_on_in(switch_on),
        .remote_mode_in(remote), .system_on_in(system_on), .hv_supply_good_in(hv_good),
        .reg_undervoltage_in(uv), .reg_overvoltage_in(ov), .fault_reset_in(fault_reset),
        .first_stage_relay_out(k1), .second_stage_relay_out(k2), .third_stage_relay_out(k3),
        .fault_indicate_relay_out(k4), .neg30_enable_n_out(neg30_n), .pos30_enable_out(pos30),
        .power_up_latch_out(latch), .turn_on_delay_pulse_out(pulse),
        .supply_fault_block_n_out(lockout_n), .memory_not_available_out(mna),
        .undervoltage_indicator_n_out(uv_ind_n), .overvoltage_indicator_n_out(ov_ind_n),
        .reg_fault_indicator_n_out(reg_ind_n));

    mps_supply_model #(.RAMP_CYC(4)) mps_supply_model_i (.clock_in(clock), .rst_n_in(rst_n),
        .sys_power_in(sys_power), .hv_request_in(hv_request), .neg30_enable_n_in(neg30_n),
        .pos30_enable_in(pos30), .supply_fault_block_n_in(lockout_n),
        .memory_not_available_in(mna), .trip_uv_in(trip_uv), .trip_ov_in(trip_ov),
        .system_on_out(system_on), .hv_supply_good_out(hv_good),
        .reg_undervoltage_out(uv), .reg_overvoltage_out(ov), .module_ready_out(ready));

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    // notes the first cycle at which each watched output leaves its entry value
    task automatic track(input int n);
        logic [6:0] snap;
        snap = mon;
        for (int b = 0; b < 7; b++) begin
            t[b] = -1;
        end
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            #1;
            for (int b = 0; b < 7; b++) begin
                if (t[b] < 0 && mon[b] !== snap[b]) begin
                    t[b] = i;
                end
            end
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic reset_values;
        check("relays", {k4, k3, k2, k1}, 32'h0);
        check("enables", {pos30, neg30_n}, 32'h1);
        check("latch and pulse", {latch, pulse}, 32'h0);
        check("lockout and mna", {lockout_n, mna}, 32'h3);
        check("indicators", {uv_ind_n, ov_ind_n, reg_ind_n}, 32'h3f);
        check("ready", ready, 1'b0);
    endtask

    // +100V present but third relay open: nothing may start
    task automatic refused_without_relays;
        @(posedge clock) hv_request <= 1'b1;
        track(20);
        check("pulse without relays", t[6], -1);
        check("latch without relays", t[5], -1);
        @(posedge clock) hv_request <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    task automatic relays_pick;
        @(posedge clock) switch_on <= 1'b1;
        track(12);
        check("first relay picked", k1 & k2 & k3, 1'b1);
        check("second after first", t[1] - t[0], 1);
        check("third after second", t[2] - t[1], 1);
        check("no early settle relay", k4, 1'b0);
        check("regulators wait for hv", neg30_n, 1'b1);
    endtask

    task automatic sequence_up;
        @(posedge clock) hv_request <= 1'b1;
        track(40);
        check("pulse fired", t[6] >= 0, 1'b1);
        check("neg30 not before pulse", t[3] >= t[6], 1'b1);
        check("latch set", latch, 1'b1);
        check("pos30 after neg30", t[4] > t[3], 1'b1);
        check("pos30 waits for uv", t[4] - t[3] >= 4, 1'b1);
        check("pulse still running", pulse, 1'b1);
        check("mna held during pulse", mna, 1'b1);
        check("lockout stays true", lockout_n, 1'b1);
        check("no faults latched", {uv_ind_n, ov_ind_n, reg_ind_n}, 32'h3f);
    endtask

    // pulse rose 5 cycles into sequence_up; this window opens 41 cycles after its start
    task automatic sequence_done;
        track(40);
        check("pulse full length", t[6], PULSE_CYC - 36);
        check("settle relay closed", k4, 1'b1);
        check("latch holds after pulse", {latch, pos30, neg30_n}, 32'h6);
        check("mna low after pulse", mna, 1'b0);
        check("exchange sees ready", ready, 1'b1);
        check("no faults after pulse", {uv_ind_n, ov_ind_n, reg_ind_n}, 32'h3f);
    endtask

    // local fault lights lamps but keeps lockout; back in remote, lockout drops
    task automatic excess_current;
        @(posedge clock) remote <= 1'b0;
        trip_uv <= 4'h1;
        trip_ov <= 4'h8;
        track(10);
        check("uv lamp lit", uv_ind_n, 1'b0);
        check("ov lamp lit", ov_ind_n, 1'b0);
        check("pos30 lamp gated", reg_ind_n, 4'he);
        check("local fault keeps lockout", {lockout_n, latch}, 32'h3);
        @(posedge clock) remote <= 1'b1;
        track(20);
        check("lockout dropped", lockout_n, 1'b0);
        check("latch cleared by lockout", latch, 1'b0);
        check("regulators down", {pos30, neg30_n}, 32'h1);
        check("pos30 drops after latch", t[4] >= t[5], 1'b1);
        check("neg30 drops after pos30", t[3] > t[4], 1'b1);
        check("no restart under lockout", t[6], -1);
        check("mna raised", {mna, ready}, 32'h2);
    endtask

    // reset button clears the latches, lockout returns and power-up restarts
    task automatic fault_cleared;
        @(posedge clock) fault_reset <= 1'b1;
        trip_uv <= 4'h0;
        trip_ov <= 4'h0;
        repeat (4) @(posedge clock);
        fault_reset <= 1'b0;
        track(20);
        check("lamps cleared", {uv_ind_n, ov_ind_n, reg_ind_n}, 32'h3f);
        check("lockout restored", lockout_n, 1'b1);
        check("pulse refired", t[6] >= 0, 1'b1);
        check("latch set again", latch, 1'b1);
    endtask

    task automatic hv_removed;
        @(posedge clock) hv_request <= 1'b0;
        track(20);
        check("latch cleared", latch, 1'b0);
        check("pos30 off after latch", t[4] >= t[5], 1'b1);
        check("neg30 off after pos30", t[3] > t[4], 1'b1);
        check("all regulators off", {pos30, neg30_n}, 32'h1);
        check("lockout stays true", lockout_n, 1'b1);
    endtask

    task automatic relays_drop;
        @(posedge clock) switch_on <= 1'b0;
        track(12);
        check("relays released", {k3, k2, k1}, 32'h0);
        check("second after third", t[1] - t[2], 1);
        check("first after second", t[0] - t[1], 1);
        check("settle relay released", k4, 1'b0);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        #1;
        reset_values();
        refused_without_relays();
        relays_pick();
        sequence_up();
        sequence_done();
        excess_current();
        fault_cleared();
        hv_removed();
        relays_drop();
        end_of_test();
    end

    // whole run needs a few hundred cycles; far above that means a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end
endmodule
`default_nettype wire
